// ---- hw/txima_regs_pkg.sv ----
// Constants for the transmit link configuration and status register bank.
// Assumes a 16-bit host port with word addresses and a single system clock.
package txima_regs_pkg;
  localparam int unsigned ADDR_W = 12; // Host word address width
  localparam int unsigned DATA_W = 16; // Host data width
  localparam int unsigned NUM_LINKS = 16; // Physical transmit links
  localparam int unsigned NUM_GROUPS = 8; // Inverse-mux groups
  localparam int unsigned ID_W = 5; // Logical label width
  localparam int unsigned PER_W = 4; // Integration period code width
  // Register offsets (word addresses)
  localparam logic [11:0] LABEL_BASE = 12'h0336;
  localparam logic [11:0] LABEL_LAST = 12'h033d;
  localparam logic [11:0] ACTIVE_ADDR = 12'h0345;
  localparam logic [11:0] MODE_ADDR = 12'h0346;
  localparam logic [11:0] GRP_CNT_ADDR = 12'h0401;
  localparam logic [11:0] LNK_CNT_ADDR = 12'h0402;
  localparam logic [11:0] RATE_BASE = 12'h0403;
  localparam logic [11:0] RATE_LAST = 12'h0406;
  // Field positions
  localparam int unsigned LABEL_LO_LSB = 0; // Lower link label, bits 4:0
  localparam int unsigned LABEL_HI_LSB = 8; // Upper link label, bits 12:8
  localparam int unsigned RATE_LO_LSB = 0; // Group n period, bits 3:0
  localparam int unsigned RATE_RSV_LSB = 4; // Reserved r/w, bits 7:4
  localparam int unsigned RATE_HI_LSB = 8; // Group n+4 period, bits 11:8
  localparam int unsigned PAIR_STRIDE = 8; // Link k pairs with link k+8
  localparam int unsigned GRP_STRIDE = 4; // Group n pairs with group n+4
  // Reset values
  localparam logic [15:0] LABEL_RST = 16'h0000;
  localparam logic [15:0] ACTIVE_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'hffff;
  localparam logic [15:0] GRP_CNT_RST = 16'h0000;
  localparam logic [15:0] LNK_CNT_RST = 16'h0000;
  localparam logic [15:0] RATE_RST = 16'h0c0c;
  localparam logic [15:0] RATE_MASK = 16'h0fff; // Bits 15:12 read zero
  localparam logic [15:0] GRP_CNT_MASK = 16'h00ff; // Bits 15:8 read zero
  localparam logic [15:0] UNMAPPED_RD = 16'h0000; // Read data off the map
  localparam logic [3:0] PERIOD_RSV = 4'hf; // Reserved period code
  localparam int unsigned PERIOD_BASE_LOG2 = 8; // Code 0 means 2**8 clocks
endpackage

// ---- hw/txima_sync2.sv ----
// Two-flop synchroniser for a vector of levels from outside the clock domain.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
module txima_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg; // Second stage, safe to use
  logic [WIDTH-1:0] q_next;

  // Shift the level along
  always_comb begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  // Register stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule

// ---- hw/txima_regs.sv ----
// Transmit link configuration and status register bank: link labels,
// activity and mode status, counter selects and rate integration periods.
// Assumes a synchronous host port (chip select, read and write strobes) on
// clk_i, and mode/start levels from the transmit core arriving unsynchronised.
module txima_regs #(
  parameter int unsigned NUM_LINKS = txima_regs_pkg::NUM_LINKS,
  parameter int unsigned NUM_GROUPS = txima_regs_pkg::NUM_GROUPS
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Host port
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // Transmit core status, asynchronous levels
  input wire logic [NUM_LINKS-1:0] link_mux_mode_i,
  input wire logic [NUM_LINKS-1:0] link_sched_started_i,
  // Configuration to the transmit core
  output logic [NUM_LINKS*5-1:0] logical_link_label_o,
  output logic [NUM_LINKS-1:0] label_valid_o,
  output logic [NUM_GROUPS-1:0] group_user_only_o,
  output logic [NUM_LINKS-1:0] link_user_only_o,
  output logic [NUM_GROUPS*4-1:0] cell_rate_estimate_period_o,
  output logic [NUM_GROUPS-1:0] period_code_rsv_o
);
  localparam int unsigned NPAIR = NUM_LINKS / 2;
  localparam int unsigned NRATE = NUM_GROUPS / 2;

  // Reset release through two flops
  logic rst_sync1_reg;
  logic rst_n; // Released reset used everywhere else
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  // Core status levels cross into this domain
  logic [NUM_LINKS-1:0] mux_mode_s; // Synchronised mux mode per link
  logic [NUM_LINKS-1:0] started_s; // Synchronised scheduler start
  txima_sync2 #(.WIDTH(NUM_LINKS), .RST_VAL('0)) u_sync_mode (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(link_mux_mode_i),
    .q_o(mux_mode_s)
  );
  txima_sync2 #(.WIDTH(NUM_LINKS), .RST_VAL('0)) u_sync_start (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(link_sched_started_i),
    .q_o(started_s)
  );

  // Register storage
  logic [15:0] label_reg [NPAIR]; // Link label pairs
  logic [15:0] label_next [NPAIR];
  logic [15:0] rate_reg [NRATE]; // Integration period pairs
  logic [15:0] rate_next [NRATE];
  logic [15:0] grp_cnt_reg; // Group counter select
  logic [15:0] grp_cnt_next;
  logic [15:0] lnk_cnt_reg; // Link counter select
  logic [15:0] lnk_cnt_next;
  logic [15:0] active_reg; // Link activity status
  logic [15:0] active_next;
  logic [15:0] mode_reg; // Mode status, one means outside mux
  logic [15:0] mode_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [NUM_LINKS*5-1:0] label_out_reg;
  logic [NUM_LINKS*5-1:0] label_out_next;
  logic [NUM_LINKS-1:0] label_vld_reg;
  logic [NUM_LINKS-1:0] label_vld_next;
  logic [NUM_GROUPS*4-1:0] period_reg;
  logic [NUM_GROUPS*4-1:0] period_next;
  logic [NUM_GROUPS-1:0] prsv_reg;
  logic [NUM_GROUPS-1:0] prsv_next;

  logic wr_en; // Qualified write strobe
  logic rd_en; // Qualified read strobe
  assign wr_en = cs_i && wr_i;
  assign rd_en = cs_i && rd_i;

  // Next state: host writes, status capture, read mux, core outputs
  always_comb begin
    logic [11:0] idx;
    idx = 12'h000;
    for (int i = 0; i < NPAIR; i++) label_next[i] = label_reg[i];
    for (int i = 0; i < NRATE; i++) rate_next[i] = rate_reg[i];
    grp_cnt_next = grp_cnt_reg;
    lnk_cnt_next = lnk_cnt_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    // Writes; label words stored whole, reserved label bits kept as written
    if (wr_en) begin
      if (addr_i >= txima_regs_pkg::LABEL_BASE &&
          addr_i <= txima_regs_pkg::LABEL_LAST) begin
        idx = addr_i - txima_regs_pkg::LABEL_BASE;
        label_next[idx[2:0]] = wdata_i;
      end else if (addr_i >= txima_regs_pkg::RATE_BASE &&
                   addr_i <= txima_regs_pkg::RATE_LAST) begin
        idx = addr_i - txima_regs_pkg::RATE_BASE;
        rate_next[idx[1:0]] = wdata_i & txima_regs_pkg::RATE_MASK;
      end else if (addr_i == txima_regs_pkg::GRP_CNT_ADDR) begin
        grp_cnt_next = wdata_i & txima_regs_pkg::GRP_CNT_MASK;
      end else if (addr_i == txima_regs_pkg::LNK_CNT_ADDR) begin
        lnk_cnt_next = wdata_i;
      end
    end
    // Mode status follows the core; active only inside mux mode
    mode_next = ~mux_mode_s;
    active_next = mux_mode_s & started_s;
    // Reads answer one cycle later; status registers are read-only
    if (rd_en) begin
      rvalid_next = 1'b1;
      rdata_next = txima_regs_pkg::UNMAPPED_RD;
      if (addr_i >= txima_regs_pkg::LABEL_BASE &&
          addr_i <= txima_regs_pkg::LABEL_LAST) begin
        idx = addr_i - txima_regs_pkg::LABEL_BASE;
        rdata_next = label_reg[idx[2:0]];
      end else if (addr_i >= txima_regs_pkg::RATE_BASE &&
                   addr_i <= txima_regs_pkg::RATE_LAST) begin
        idx = addr_i - txima_regs_pkg::RATE_BASE;
        rdata_next = rate_reg[idx[1:0]];
      end else if (addr_i == txima_regs_pkg::ACTIVE_ADDR) begin
        rdata_next = active_reg;
      end else if (addr_i == txima_regs_pkg::MODE_ADDR) begin
        rdata_next = mode_reg;
      end else if (addr_i == txima_regs_pkg::GRP_CNT_ADDR) begin
        rdata_next = grp_cnt_reg;
      end else if (addr_i == txima_regs_pkg::LNK_CNT_ADDR) begin
        rdata_next = lnk_cnt_reg;
      end
    end
    // Labels to the core, valid only for links in mux mode
    for (int k = 0; k < NPAIR; k++) begin
      label_out_next[k*5 +: 5] =
        label_reg[k][txima_regs_pkg::LABEL_LO_LSB +: 5];
      label_out_next[(k+txima_regs_pkg::PAIR_STRIDE)*5 +: 5] =
        label_reg[k][txima_regs_pkg::LABEL_HI_LSB +: 5];
    end
    label_vld_next = mux_mode_s;
    // Period codes and reserved-code flags per group
    for (int n = 0; n < NRATE; n++) begin
      period_next[n*4 +: 4] = rate_reg[n][txima_regs_pkg::RATE_LO_LSB +: 4];
      period_next[(n+txima_regs_pkg::GRP_STRIDE)*4 +: 4] =
        rate_reg[n][txima_regs_pkg::RATE_HI_LSB +: 4];
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      prsv_next[g] =
        (period_next[g*4 +: 4] == txima_regs_pkg::PERIOD_RSV);
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NPAIR; i++)
        label_reg[i] <= txima_regs_pkg::LABEL_RST;
      for (int i = 0; i < NRATE; i++) rate_reg[i] <= txima_regs_pkg::RATE_RST;
      grp_cnt_reg <= txima_regs_pkg::GRP_CNT_RST;
      lnk_cnt_reg <= txima_regs_pkg::LNK_CNT_RST;
      active_reg <= txima_regs_pkg::ACTIVE_RST;
      mode_reg <= txima_regs_pkg::MODE_RST;
      rdata_reg <= txima_regs_pkg::UNMAPPED_RD;
      rvalid_reg <= 1'b0;
      label_out_reg <= '0;
      label_vld_reg <= '0;
      period_reg <= '0;
      prsv_reg <= '0;
    end else begin
      label_reg <= label_next;
      rate_reg <= rate_next;
      grp_cnt_reg <= grp_cnt_next;
      lnk_cnt_reg <= lnk_cnt_next;
      active_reg <= active_next;
      mode_reg <= mode_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      label_out_reg <= label_out_next;
      label_vld_reg <= label_vld_next;
      period_reg <= period_next;
      prsv_reg <= prsv_next;
    end
  end

  // Outputs straight from flops
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign logical_link_label_o = label_out_reg;
  assign label_valid_o = label_vld_reg;
  assign group_user_only_o = grp_cnt_reg[NUM_GROUPS-1:0];
  assign link_user_only_o = lnk_cnt_reg[NUM_LINKS-1:0];
  assign cell_rate_estimate_period_o = period_reg;
  assign period_code_rsv_o = prsv_reg;
endmodule

// ---- tb/txima_chk_props.sv ----
// Checker for the link register bank, bound to each bank instance.
// Assumes the host strobes are driven between clock edges.
module txima_chk #(
  parameter int unsigned NUM_LINKS = 16,
  parameter int unsigned NUM_GROUPS = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [NUM_LINKS-1:0] link_mux_mode_i,
  input wire logic [NUM_LINKS*5-1:0] logical_link_label_o,
  input wire logic [NUM_LINKS-1:0] label_valid_o,
  input wire logic [NUM_GROUPS-1:0] group_user_only_o,
  input wire logic [NUM_LINKS-1:0] link_user_only_o,
  input wire logic [NUM_GROUPS*4-1:0] cell_rate_estimate_period_o,
  input wire logic [NUM_GROUPS-1:0] period_code_rsv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Host write taken at one address
  sequence wr_at(a);
    cs_i && wr_i && addr_i == a;
  endsequence
  // Host read taken inside an address range
  sequence rd_in(lo, hi);
    cs_i && rd_i && addr_i >= lo && addr_i <= hi;
  endsequence
  read_answer_a: assert property ((cs_i && rd_i) |=> rvalid_o)
    else $error("read not answered next cycle");
  // Read valid is a pulse: never shown without a read one cycle before
  read_pulse_a: assert property (!(cs_i && rd_i) |=> !rvalid_o)
    else $error("read valid without a read");
  grp_high_zero_a: assert property (rd_in(12'h0401, 12'h0401) |=>
    rdata_o[15:8] == 8'h00) else $error("group select high byte set");
  rate_high_zero_a: assert property (rd_in(12'h0403, 12'h0406) |=>
    rdata_o[15:12] == 4'h0) else $error("rate register high bits set");
  grp_sel_out_a: assert property (wr_at(12'h0401) |-> ##2
    group_user_only_o == $past(wdata_i[7:0], 2))
    else $error("group select output wrong");
  lnk_sel_out_a: assert property (wr_at(12'h0402) |-> ##2
    link_user_only_o == $past(wdata_i, 2)) else $error("link select wrong");
  label_out_a: assert property (wr_at(12'h0336) |-> ##2
    logical_link_label_o[44:40] == $past(wdata_i[12:8], 2) &&
    logical_link_label_o[4:0] == $past(wdata_i[4:0], 2))
    else $error("label pair output wrong");
  rate_out_a: assert property (wr_at(12'h0403) |-> ##2
    cell_rate_estimate_period_o[19:16] == $past(wdata_i[11:8], 2) &&
    cell_rate_estimate_period_o[3:0] == $past(wdata_i[3:0], 2))
    else $error("period pair output wrong");
  label_valid_a: assert property ($stable(link_mux_mode_i)[*8] |->
    label_valid_o == link_mux_mode_i) else $error("label valid wrong");
  period_rsv_a: assert property (period_code_rsv_o[0] ==
    (cell_rate_estimate_period_o[3:0] == 4'hf)) else $error("rsv flag");
endmodule

bind txima_regs txima_chk #(.NUM_LINKS(NUM_LINKS), .NUM_GROUPS(NUM_GROUPS))
  u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_i(cs_i), .rd_i(rd_i),
  .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .link_mux_mode_i(link_mux_mode_i),
  .logical_link_label_o(logical_link_label_o),
  .label_valid_o(label_valid_o), .group_user_only_o(group_user_only_o),
  .link_user_only_o(link_user_only_o),
  .cell_rate_estimate_period_o(cell_rate_estimate_period_o),
  .period_code_rsv_o(period_code_rsv_o));

// ---- tb/testbench.sv ----
// Self-checking bench for the link register bank, with a bench model.
// Assumes the checker is bound in by its own file.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, arst_n_i = 0, cs_i = 0, rd_i = 0, wr_i = 0, rvalid_o;
  logic [11:0] addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o, mux = '0, st = '0, lv_o, lu_o;
  logic [79:0] lab_o;
  logic [7:0] gu_o, rsv_o;
  logic [31:0] per_o, seed = 32'h0000_b5fa;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  int lbl[8], rate[4], grp, lnk; // Model registers
  txima_regs u_txima_regs (.clk_i, .arst_n_i, .cs_i, .rd_i, .wr_i, .addr_i,
    .wdata_i, .rdata_o, .rvalid_o, .link_mux_mode_i(mux),
    .link_sched_started_i(st), .logical_link_label_o(lab_o),
    .label_valid_o(lv_o), .group_user_only_o(gu_o), .link_user_only_o(lu_o),
    .cell_rate_estimate_period_o(per_o), .period_code_rsv_o(rsv_o));
  initial forever #5 clk_i = ~clk_i;
  // Hang guard, far above the roughly 780 cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [79:0] e, logic [79:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Expected read data; status follows the inputs, not sticky
  function automatic logic [15:0] mdl(logic [11:0] a);
    if (a >= 12'h0336 && a <= 12'h033d) return 16'(lbl[a - 12'h0336]);
    if (a >= 12'h0403 && a <= 12'h0406) return 16'(rate[a - 12'h0403]);
    case (a)
      12'h0345: return mux & st;
      12'h0346: return ~mux;
      12'h0401: return 16'(grp);
      12'h0402: return 16'(lnk);
      default: return 16'h0000;
    endcase
  endfunction
  // Host cycles: strobes held one full clock, dropped a clock later
  task automatic rd(logic [11:0] a);
    @(negedge clk_i);
    {cs_i, rd_i, addr_i} = {2'b11, a};
    @(negedge clk_i);
    {cs_i, rd_i} = 2'b00;
    chk("rvalid", 80'(1), 80'(rvalid_o));
    chk("rdata", 80'(mdl(a)), 80'(rdata_o));
  endtask
  task automatic mw(logic [11:0] a, logic [15:0] d);
    @(negedge clk_i);
    {cs_i, wr_i, addr_i, wdata_i} = {2'b11, a, d};
    @(negedge clk_i);
    {cs_i, wr_i} = 2'b00;
    // Read-only and unmapped places keep the model unchanged
    if (a >= 12'h0336 && a <= 12'h033d) lbl[a - 12'h0336] = d;
    else if (a >= 12'h0403 && a <= 12'h0406) rate[a - 12'h0403] = d & 16'h0fff;
    else if (a == 12'h0401) grp = d & 16'h00ff;
    else if (a == 12'h0402) lnk = d;
  endtask
  // Whole map plus unmapped neighbours
  task automatic rd_all();
    for (int a = 12'h0336; a <= 12'h0347; a++) rd(12'(a));
    for (int a = 12'h0400; a <= 12'h0407; a++) rd(12'(a));
  endtask
  task automatic chk_out();
    logic [79:0] el;
    logic [31:0] ep;
    logic [7:0] er;
    for (int k = 0; k < 8; k++) begin
      el[k*5+:5] = lbl[k][4:0];
      el[(k+8)*5+:5] = lbl[k][12:8];
      ep[(k%4+4*(k/4))*4+:4] = (k < 4) ? rate[k][3:0] : rate[k-4][11:8];
    end
    for (int g = 0; g < 8; g++) er[g] = (ep[g*4+:4] == 4'hf);
    chk("label", el, lab_o);
    chk("period", 80'(ep), 80'(per_o));
    chk("period_rsv", 80'(er), 80'(rsv_o));
    chk("grp_sel", 80'(grp), 80'(gu_o));
    chk("lnk_sel", 80'(lnk), 80'(lu_o));
    chk("label_valid", 80'(mux), 80'(lv_o));
  endtask
  task automatic do_reset();
    arst_n_i = 0;
    repeat (5) @(negedge clk_i);
    arst_n_i = 1;
    foreach (lbl[i]) lbl[i] = 0;
    foreach (rate[i]) rate[i] = 16'h0c0c;
    grp = 0;
    lnk = 0;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset map, then random config and status, one reset in mid-run
  initial begin
    do_reset();
    rd_all();
    chk_out();
    for (int it = 0; it < 6; it++) begin
      @(negedge clk_i);
      {mux, st} = xs();
      for (int a = 12'h0336; a <= 12'h0346; a++)
        mw(12'(a), 16'(xs()) & 16'h1f1f);
      for (int a = 12'h0401; a <= 12'h0406; a++) mw(12'(a), xs());
      repeat (6) @(negedge clk_i);
      chk_out();
      rd_all();
      // Mid-run reset: config and its outputs back to reset values; status and label valid follow mux and st
      if (it == 3) begin
        do_reset();
        rd_all();
        chk_out();
      end
    end
    // All links in mux mode, group 0 period code b; link 0 then leaves mux mode
    mux = 16'hffff;
    mw(12'h0403, 16'h000b);
    repeat (4) @(negedge clk_i);
    mux[0] = 1'b0;
    // Config held until mode status can report the link out
    repeat (4) @(negedge clk_i);
    rd(12'h0346);
    rd(12'h0345);
    chk_out();
    finish_test();
  end
endmodule
